// ---- hdl/lcc_top.sv ----
`default_nettype none
// ==========================================================================
module lcc_top
   import lcc_pkg::*;
#(
   parameter int COL_W = 8
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone classic slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Strap pins.
   input wire logic master_select_i,
   input wire logic osc_source_select_i,
   // Oscillator controls.
   output logic osc_enable_o,
   output logic [3:0] osc_freq_sel_o,
   // Power circuit controls.
   output logic stepup_enable_o,
   output logic v3_regulator_enable_o,
   output logic drive_voltage_gen_enable_o,
   output logic [2:0] v3_range_o,
   // Column and display data access.
   output logic rmw_active_o,
   output logic [COL_W-1:0] column_o,
   output logic disp_rd_o,
   output logic disp_wr_o,
   output logic [7:0] disp_wr_data_o
);

   // =======================================================================
   // Elaboration checks.
   if (COL_W < 1 || COL_W > 16) begin : g_col_w_check
      $error("COL_W must lie between 1 and 16");
   end

   // =======================================================================
   // Declarations.
   lcc_col_if #(.COL_W(COL_W)) col_bus ();

   logic [1:0] strap_sync;
   logic master_sync;
   logic cls_sync;
   logic access;
   logic wr_access;
   logic rd_access;
   logic lane0;
   logic lane1;
   logic byte_stb;
   logic byte_is_param;
   logic [7:0] byte_val;
   logic [31:0] status_word;
   logic [31:0] nxt_rd_data;

   logic ack_ff;
   logic [31:0] rd_data_ff;
   logic [8:0] last_byte_ff;
   lcc_pend_t pend_ff;
   logic osc_ff;
   logic [3:0] freq_ff;
   logic [2:0] pwr_ff;
   logic [2:0] v3_ff;
   logic disp_rd_ff;
   logic disp_wr_ff;
   logic [7:0] disp_data_ff;
   logic rmw_out_ff;
   logic [COL_W-1:0] col_out_ff;

   // =======================================================================
   // Functions.

   // True when an address falls in the word at the given register offset.
   function automatic logic is_reg(input logic [3:0] adr,
                                   input logic [3:0] ofs);
      is_reg = (adr[3:2] == ofs[3:2]);
   endfunction : is_reg

   // Next pending parameter for an opcode byte.
   function automatic lcc_pend_t pend_of(input logic [7:0] op);
      case (op)
         LCC_OP_OSC_FREQ: pend_of = LCC_PEND_FREQ;
         LCC_OP_PWR_CTRL: pend_of = LCC_PEND_PWR;
         LCC_OP_V3_RANGE: pend_of = LCC_PEND_V3;
         default: pend_of = LCC_PEND_NONE;
      endcase
   endfunction : pend_of

   // =======================================================================
   // Strap synchronisers.
   lcc_sync #(
      .WIDTH(2)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i({osc_source_select_i, master_select_i}),
      .sync_o(strap_sync)
   );

   assign master_sync = strap_sync[0];
   assign cls_sync = strap_sync[1];

   // =======================================================================
   // Column counter.
   lcc_col_ctr #(
      .COL_W(COL_W)
   ) u_col (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .col_bus(col_bus)
   );

   // =======================================================================
   // Bus decode.

   // A request is taken in the cycle before its acknowledge.
   assign access = wb_cyc_i && wb_stb_i && !ack_ff;
   assign wr_access = access && wb_we_i;
   assign rd_access = access && !wb_we_i;
   assign lane0 = wb_sel_i[0];
   assign lane1 = wb_sel_i[1];

   // A command register write with both low lanes carries one host byte.
   assign byte_stb = wr_access && is_reg(wb_adr_i, LCC_OFS_CMD) &&
                     lane0 && lane1;
   assign byte_is_param = wb_dat_i[LCC_CMD_SEL_BIT];
   assign byte_val = wb_dat_i[7:0];

   // =======================================================================
   // Column events toward the counter.

   // Opcodes enter or leave the mode; data writes, and data reads outside the mode, move the column.
   always_comb begin
      col_bus.rmw_enter = byte_stb && !byte_is_param &&
                          (byte_val == LCC_OP_RMW);
      col_bus.rmw_end = byte_stb && !byte_is_param &&
                        (byte_val == LCC_OP_END);
      col_bus.set_stb = wr_access && is_reg(wb_adr_i, LCC_OFS_COLUMN) &&
                        lane0;
      col_bus.set_val = wb_dat_i[COL_W-1:0];
      col_bus.wr_stb = wr_access && is_reg(wb_adr_i, LCC_OFS_DATA) &&
                       lane0;
      col_bus.rd_stb = rd_access && is_reg(wb_adr_i, LCC_OFS_DATA);
   end

   // =======================================================================
   // Bus acknowledge.

   // One acknowledge per request, dropped in the following cycle.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= access;
      end
   end

   // =======================================================================
   // Read data.

   // Status word gathers the block's own state.
   always_comb begin
      status_word = '0;
      status_word[LCC_ST_RMW_BIT] = col_bus.rmw_active;
      status_word[LCC_ST_OSC_BIT] = osc_ff;
      status_word[LCC_ST_FREQ_LSB +: 4] = freq_ff;
      status_word[LCC_ST_PWR_LSB +: 3] = pwr_ff;
      status_word[LCC_ST_V3_LSB +: 3] = v3_ff;
      status_word[LCC_ST_MASTER_BIT] = master_sync;
      status_word[LCC_ST_CLS_BIT] = cls_sync;
      status_word[LCC_ST_PEND_LSB +: 2] = pend_ff;
   end

   // Unmapped offsets and the data word read as zero.
   always_comb begin
      nxt_rd_data = '0;
      if (is_reg(wb_adr_i, LCC_OFS_CMD)) begin
         nxt_rd_data[8:0] = last_byte_ff;
      end else if (is_reg(wb_adr_i, LCC_OFS_STATUS)) begin
         nxt_rd_data = status_word;
      end else if (is_reg(wb_adr_i, LCC_OFS_COLUMN)) begin
         nxt_rd_data[COL_W-1:0] = col_bus.col;
      end
   end

   // Read data is caught with the acknowledge and held after it.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_data_ff <= '0;
      end else if (rd_access) begin
         rd_data_ff <= nxt_rd_data;
      end
   end

   // =======================================================================
   // Host byte log.

   // The last byte and its select bit stay readable for software.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         last_byte_ff <= '0;
      end else if (byte_stb) begin
         last_byte_ff <= {byte_is_param, byte_val};
      end
   end

   // =======================================================================
   // Command decoder.

   // An opcode arms the parameter slot; a parameter consumes it.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pend_ff <= LCC_PEND_NONE;
      end else if (byte_stb) begin
         if (!byte_is_param) begin
            pend_ff <= pend_of(byte_val);
         end else begin
            pend_ff <= LCC_PEND_NONE;
         end
      end
   end

   // Oscillator on only with master and built-in source straps high.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         osc_ff <= LCC_RST_OSC;
      end else if (byte_stb && !byte_is_param) begin
         if (byte_val == LCC_OP_OSC_OFF) begin
            osc_ff <= 1'b0;
         end else if (byte_val == LCC_OP_OSC_ON && master_sync &&
                      cls_sync) begin
            osc_ff <= 1'b1;
         end
      end
   end

   // Frequency select takes only the low four parameter bits.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         freq_ff <= LCC_RST_FREQ;
      end else if (byte_stb && byte_is_param &&
                   pend_ff == LCC_PEND_FREQ) begin
         freq_ff <= byte_val[3:0];
      end
   end

   // Power enables take bits 2..0 of their parameter.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pwr_ff <= LCC_RST_PWR;
      end else if (byte_stb && byte_is_param &&
                   pend_ff == LCC_PEND_PWR) begin
         pwr_ff <= byte_val[2:0];
      end
   end

   // V3 range takes the low three parameter bits.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         v3_ff <= LCC_RST_V3;
      end else if (byte_stb && byte_is_param &&
                   pend_ff == LCC_PEND_V3) begin
         v3_ff <= byte_val[2:0];
      end
   end

   // =======================================================================
   // Display data strobes.

   // One-cycle pulses toward the display memory, with the write byte.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         disp_rd_ff <= 1'b0;
         disp_wr_ff <= 1'b0;
      end else begin
         disp_rd_ff <= col_bus.rd_stb;
         disp_wr_ff <= col_bus.wr_stb;
      end
   end

   // Write data is held from the last display write.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         disp_data_ff <= '0;
      end else if (col_bus.wr_stb) begin
         disp_data_ff <= wb_dat_i[7:0];
      end
   end

   // =======================================================================
   // Registered copies of the column state for the pins.

   // Follows the counter one cycle late so that outputs leave flops.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rmw_out_ff <= LCC_RST_RMW;
         col_out_ff <= '0;
      end else begin
         rmw_out_ff <= col_bus.rmw_active;
         col_out_ff <= col_bus.col;
      end
   end

   // =======================================================================
   // Output drive.
   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rd_data_ff;
   assign osc_enable_o = osc_ff;
   assign osc_freq_sel_o = freq_ff;
   assign stepup_enable_o = pwr_ff[2];
   assign v3_regulator_enable_o = pwr_ff[1];
   assign drive_voltage_gen_enable_o = pwr_ff[0];
   assign v3_range_o = v3_ff;
   assign rmw_active_o = rmw_out_ff;
   assign column_o = col_out_ff;
   assign disp_rd_o = disp_rd_ff;
   assign disp_wr_o = disp_wr_ff;
   assign disp_wr_data_o = disp_data_ff;

endmodule : lcc_top
`default_nettype wire

// ---- shared/lcc_pkg.sv ----
`default_nettype none
// ==========================================================================
// Shared constants of the LCD command controller.
package lcc_pkg;

   // =======================================================================
   // Register byte offsets on the Wishbone bus.
   localparam logic [3:0] LCC_OFS_CMD = 4'h0;
   localparam logic [3:0] LCC_OFS_STATUS = 4'h4;
   localparam logic [3:0] LCC_OFS_COLUMN = 4'h8;
   localparam logic [3:0] LCC_OFS_DATA = 4'hc;

   // =======================================================================
   // Command opcodes.
   localparam logic [7:0] LCC_OP_RMW = 8'he0;
   localparam logic [7:0] LCC_OP_END = 8'hee;
   localparam logic [7:0] LCC_OP_OSC_OFF = 8'haa;
   localparam logic [7:0] LCC_OP_OSC_ON = 8'hab;
   localparam logic [7:0] LCC_OP_OSC_FREQ = 8'h5f;
   localparam logic [7:0] LCC_OP_PWR_CTRL = 8'h25;
   localparam logic [7:0] LCC_OP_V3_RANGE = 8'h2b;

   // =======================================================================
   // Field positions in the command register and the status word.
   localparam int LCC_CMD_SEL_BIT = 8;
   localparam int LCC_ST_RMW_BIT = 0;
   localparam int LCC_ST_OSC_BIT = 1;
   localparam int LCC_ST_FREQ_LSB = 4;
   localparam int LCC_ST_PWR_LSB = 8;
   localparam int LCC_ST_V3_LSB = 12;
   localparam int LCC_ST_MASTER_BIT = 16;
   localparam int LCC_ST_CLS_BIT = 17;
   localparam int LCC_ST_PEND_LSB = 20;

   // =======================================================================
   // Values after reset.
   localparam logic LCC_RST_OSC = 1'b0;
   localparam logic [3:0] LCC_RST_FREQ = 4'h0;
   localparam logic [2:0] LCC_RST_PWR = 3'h0;
   localparam logic [2:0] LCC_RST_V3 = 3'h0;
   localparam logic LCC_RST_RMW = 1'b0;

   // Parameter byte expected after a multi-byte opcode.
   typedef enum logic [1:0] {
      LCC_PEND_NONE,
      LCC_PEND_FREQ,
      LCC_PEND_PWR,
      LCC_PEND_V3
   } lcc_pend_t;

endpackage : lcc_pkg
`default_nettype wire

// ---- shared/lcc_col_if.sv ----
`default_nettype none
// ==========================================================================
// Column address control between the decoder and the column counter.
interface lcc_col_if #(parameter int COL_W = 8);
   logic set_stb;
   logic [COL_W-1:0] set_val;
   logic rd_stb;
   logic wr_stb;
   logic rmw_enter;
   logic rmw_end;
   logic [COL_W-1:0] col;
   logic rmw_active;

   // The decoder issues events, the counter reports its state.
   modport ctrl (output set_stb, set_val, rd_stb, wr_stb, rmw_enter,
                 rmw_end, input col, rmw_active);
   modport ctr (input set_stb, set_val, rd_stb, wr_stb, rmw_enter,
                rmw_end, output col, rmw_active);
endinterface : lcc_col_if
`default_nettype wire

// ---- hdl/lcc_sync.sv ----
`default_nettype none
// ==========================================================================
// Two-stage synchroniser for pin levels.
module lcc_sync #(
   parameter int WIDTH = 2
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Asynchronous levels and their synchronised copies.
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   // The first stage feeds only the second stage.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= async_i;
         sync_ff <= meta_ff;
      end
   end

   assign sync_o = sync_ff;

endmodule : lcc_sync
`default_nettype wire

// ---- hdl/lcc_col_ctr.sv ----
`default_nettype none
// ==========================================================================
// Column address counter with read-modify-write save and restore.
module lcc_col_ctr
   import lcc_pkg::*;
#(
   parameter int COL_W = 8
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Events in, column state out.
   lcc_col_if.ctr col_bus
);

   logic [COL_W-1:0] col_ff;
   logic [COL_W-1:0] saved_ff;
   logic rmw_ff;

   // Mode flag: entered once, left only by the end opcode.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rmw_ff <= LCC_RST_RMW;
      end else if (col_bus.rmw_end) begin
         rmw_ff <= 1'b0;
      end else if (col_bus.rmw_enter) begin
         rmw_ff <= 1'b1;
      end
   end

   // The column seen on entry is kept for the restore.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         saved_ff <= '0;
      end else if (col_bus.rmw_enter && !rmw_ff) begin
         saved_ff <= col_ff;
      end
   end

   // Column address: restore, set, or advance on data writes and on data reads outside the mode.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         col_ff <= '0;
      end else if (col_bus.rmw_end && rmw_ff) begin
         col_ff <= saved_ff;
      end else if (col_bus.set_stb) begin
         col_ff <= col_bus.set_val;
      end else if (col_bus.wr_stb) begin
         col_ff <= col_ff + 1'b1;
      end else if (col_bus.rd_stb && !rmw_ff) begin
         col_ff <= col_ff + 1'b1;
      end
   end

   assign col_bus.col = col_ff;
   assign col_bus.rmw_active = rmw_ff;

endmodule : lcc_col_ctr
`default_nettype wire

// ---- verif/lcc_properties.sv ----
`default_nettype none
// ==========================================================================
// Port-level properties of the LCD command controller.
module lcc_properties #(
   parameter int COL_W = 8
) (
   // Clock, reset and bus.
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   // Straps and controls.
   input wire logic master_select_i,
   input wire logic osc_source_select_i,
   input wire logic osc_enable_o,
   input wire logic [3:0] osc_freq_sel_o,
   input wire logic stepup_enable_o,
   input wire logic v3_regulator_enable_o,
   input wire logic drive_voltage_gen_enable_o,
   input wire logic [2:0] v3_range_o,
   // Column state.
   input wire logic rmw_active_o,
   input wire logic [COL_W-1:0] column_o,
   input wire logic disp_rd_o,
   input wire logic disp_wr_o
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // ========================================================================
   // Helper logic.
   logic [2:0] pwr;
   logic [COL_W-1:0] saved_ff;

   // Power enables gathered most significant first.
   assign pwr = {stepup_enable_o, v3_regulator_enable_o,
                 drive_voltage_gen_enable_o};

   // Column seen when the mode is entered, to judge the restore.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         saved_ff <= '0;
      end else if ($rose(rmw_active_o)) begin
         saved_ff <= column_o;
      end
   end

   // ========================================================================
   // Assertions.
   chk_ack_one_cycle: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not a single cycle after request");
   chk_osc_straps: assert property (
      $rose(osc_enable_o) |-> $past(master_select_i, 3)
         && $past(osc_source_select_i, 3))
      else $error("oscillator turned on without both straps high");
   chk_osc_value: assert property (
      $changed(osc_enable_o) |-> wb_ack_o && !$past(wb_dat_i[8])
         && osc_enable_o == $past(wb_dat_i[0]))
      else $error("oscillator state not from opcode bit 0");
   chk_freq_param: assert property (
      $changed(osc_freq_sel_o) |-> wb_ack_o && $past(wb_dat_i[8])
         && osc_freq_sel_o == $past(wb_dat_i[3:0]))
      else $error("frequency select not from parameter low bits");
   chk_pwr_param: assert property (
      $changed(pwr) |-> wb_ack_o && $past(wb_dat_i[8])
         && pwr == $past(wb_dat_i[2:0]))
      else $error("power enables not from parameter bits");
   chk_v3_param: assert property (
      $changed(v3_range_o) |-> wb_ack_o && $past(wb_dat_i[8])
         && v3_range_o == $past(wb_dat_i[2:0]))
      else $error("range select not from parameter low bits");
   chk_rmw_read_hold: assert property (
      disp_rd_o && rmw_active_o |=> $stable(column_o))
      else $error("column moved on a read in the mode");
   chk_rmw_write_step: assert property (
      disp_wr_o && rmw_active_o |=>
         column_o == COL_W'($past(column_o) + 1'b1))
      else $error("column did not step on a write in the mode");
   chk_rmw_enter: assert property (
      $rose(rmw_active_o) |-> $past(wb_dat_i[8:0], 2) == 9'h0e0)
      else $error("mode entered without its opcode");
   chk_rmw_restore: assert property (
      $fell(rmw_active_o) |-> column_o == saved_ff)
      else $error("column not restored when the mode ended");
   chk_reset_values: assert property (
      $fell(rst_i) |-> !osc_enable_o && !rmw_active_o
         && osc_freq_sel_o == 4'h0 && pwr == 3'h0 && v3_range_o == 3'h0)
      else $error("state not cleared by reset");

   // Main scenarios reached.
   cover property ($rose(rmw_active_o));
   cover property (disp_wr_o && rmw_active_o);
   cover property ($rose(osc_enable_o));
endmodule : lcc_properties

bind lcc_top lcc_properties #(.COL_W(COL_W)) u_lcc_properties (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
   .master_select_i(master_select_i),
   .osc_source_select_i(osc_source_select_i),
   .osc_enable_o(osc_enable_o), .osc_freq_sel_o(osc_freq_sel_o),
   .stepup_enable_o(stepup_enable_o),
   .v3_regulator_enable_o(v3_regulator_enable_o),
   .drive_voltage_gen_enable_o(drive_voltage_gen_enable_o),
   .v3_range_o(v3_range_o), .rmw_active_o(rmw_active_o),
   .column_o(column_o), .disp_rd_o(disp_rd_o), .disp_wr_o(disp_wr_o));
`default_nettype wire

// ---- verif/lcc_host_model.sv ----
`default_nettype none
// ==========================================================================
// Host processor model: classic Wishbone single-cycle master.
module lcc_host_model (
   // Clock.
   input wire logic clk_i,
   // Request towards the controller.
   output logic cyc_o,
   output logic stb_o,
   output logic we_o,
   output logic [3:0] adr_o,
   output logic [3:0] sel_o,
   output logic [31:0] dat_o,
   // Answer from the controller.
   input wire logic ack_i,
   input wire logic [31:0] rdat_i
);
   timeunit 1ns;
   timeprecision 1ps;

   // Bus idle at time zero.
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o = 1'b0;
      adr_o = 4'h0;
      sel_o = 4'h0;
      dat_o = 32'h0;
   end

   // One transfer; the request is held until ack is seen, then released.
   task automatic xfer(input logic w, input logic [3:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= w;
      adr_o <= a;
      sel_o <= 4'hf;
      dat_o <= d;
      // No cycle budget here: only the bench watchdog ends a lost answer.
      do begin
         @(posedge clk_i);
      end while (ack_i !== 1'b1);
      q = rdat_i;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      dat_o <= ~d; // Released data does not keep the last value.
   endtask : xfer
endmodule : lcc_host_model
`default_nettype wire

// ---- verif/lcc_top_bench.sv ----
`default_nettype none
// ==========================================================================
// Self-checking bench of the LCD command controller.
module lcc_top_bench;
   import lcc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ms_i = 1'b0;
   logic cs_i = 1'b0;
   logic cyc, stb, we, ack, osc, sup, reg_en, drv, rmw, drd, dwr;
   logic [3:0] adr, sel, freq;
   logic [31:0] wdat, rdat, q;
   logic [2:0] v3;
   logic [7:0] col, wbyte;
   logic [10:0] cfg;
   int n_errors = 0;
   int checks_done = 0;
   int n_rd = 0;
   int n_wr = 0;

   // Oscillator, frequency, power and range outputs side by side.
   assign cfg = {osc, freq, sup, reg_en, drv, v3};

   always #5 clk_i = ~clk_i;

   // Display strobes are counted at the edge that closes their cycle.
   always @(posedge clk_i) begin
      if (drd === 1'b1) begin
         n_rd++;
      end
      if (dwr === 1'b1) begin
         n_wr++;
      end
   end

   lcc_host_model u_lcc_host_model (.clk_i(clk_i), .cyc_o(cyc),
      .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat),
      .ack_i(ack), .rdat_i(rdat));

   lcc_top u_lcc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .master_select_i(ms_i), .osc_source_select_i(cs_i),
      .osc_enable_o(osc), .osc_freq_sel_o(freq), .stepup_enable_o(sup),
      .v3_regulator_enable_o(reg_en), .drive_voltage_gen_enable_o(drv),
      .v3_range_o(v3), .rmw_active_o(rmw), .column_o(col),
      .disp_rd_o(drd), .disp_wr_o(dwr), .disp_wr_data_o(wbyte));

   // ========================================================================
   // Shared tasks.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask : chk

   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : test_done

   // Bus writes of an opcode and of a parameter, then let outputs land.
   task automatic cmd(input logic [7:0] b);
      u_lcc_host_model.xfer(1'b1, LCC_OFS_CMD, {24'h0, b}, q);
      repeat (2) @(negedge clk_i);
   endtask : cmd

   task automatic prm(input logic [7:0] b);
      u_lcc_host_model.xfer(1'b1, LCC_OFS_CMD, {23'h0, 1'b1, b}, q);
      repeat (2) @(negedge clk_i);
   endtask : prm

   task automatic acc(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
      u_lcc_host_model.xfer(w, a, d, q);
      repeat (2) @(negedge clk_i);
   endtask : acc

   // ========================================================================
   // Scenarios.
   task automatic t_reset;
      chk(32'(cfg), 32'h0);
      chk(32'(rmw), 32'h0);
      acc(1'b1, LCC_OFS_STATUS, 32'hffffffff);
      chk(32'(cfg), 32'h0);
      acc(1'b0, LCC_OFS_STATUS, 32'h0);
      chk(q, 32'h0);
      $display("test reset done");
   endtask : t_reset

   task automatic t_osc;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_i);
         ms_i <= i[1];
         cs_i <= i[0];
         repeat (4) @(posedge clk_i);
         cmd(LCC_OP_OSC_ON);
         chk(32'(osc), 32'(i == 3));
         cmd(LCC_OP_OSC_OFF);
         chk(32'(osc), 32'h0);
      end
      cmd(LCC_OP_OSC_ON);
      chk(32'(osc), 32'h1);
      $display("test oscillator done");
   endtask : t_osc

   task automatic t_freq;
      for (int v = 0; v < 16; v++) begin
         cmd(LCC_OP_OSC_FREQ);
         prm({~v[3:0], v[3:0]});
         chk(32'(freq), 32'(v));
      end
      prm(8'h00);
      chk(32'(freq), 32'hf);
      $display("test frequency done");
   endtask : t_freq

   task automatic t_pwr;
      for (int v = 7; v >= 0; v--) begin
         cmd(LCC_OP_PWR_CTRL);
         prm({5'h0, v[2:0]});
         chk(32'({sup, reg_en, drv}), 32'(v));
      end
      cmd(LCC_OP_OSC_OFF);
      chk(32'(cfg), 32'h3c0);
      $display("test power done");
   endtask : t_pwr

   task automatic t_v3;
      for (int v = 0; v < 8; v++) begin
         cmd(LCC_OP_V3_RANGE);
         prm({5'h1f, v[2:0]});
         chk(32'(v3), 32'(v));
      end
      cmd(LCC_OP_V3_RANGE);
      cmd(8'h02);
      prm(8'h02);
      chk(32'(v3), 32'h7);
      $display("test range done");
   endtask : t_v3

   task automatic t_rmw;
      acc(1'b1, LCC_OFS_COLUMN, 32'h3e);
      acc(1'b0, LCC_OFS_COLUMN, 32'h0);
      chk(q, 32'h3e);
      cmd(LCC_OP_RMW);
      chk(32'(rmw), 32'h1);
      // Mode on, frequency 0xf, range 7, both straps high.
      acc(1'b0, LCC_OFS_STATUS, 32'h0);
      chk(q, 32'h000370f1);
      acc(1'b0, LCC_OFS_DATA, 32'h0);
      acc(1'b0, LCC_OFS_DATA, 32'h0);
      chk(32'(col), 32'h3e);
      acc(1'b1, LCC_OFS_DATA, 32'h5a);
      chk(32'(col), 32'h3f);
      chk(32'(wbyte), 32'h5a);
      cmd(LCC_OP_OSC_FREQ);
      prm(8'h03);
      chk(32'(freq), 32'h3);
      acc(1'b1, LCC_OFS_DATA, 32'ha5);
      chk(32'(col), 32'h40);
      cmd(LCC_OP_END);
      chk(32'(col), 32'h3e);
      chk(32'(rmw), 32'h0);
      chk(32'(n_rd), 32'h2);
      chk(32'(n_wr), 32'h2);
      $display("test read-modify-write done");
   endtask : t_rmw

   // ========================================================================
   // Main sequence and watchdog.
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(negedge clk_i);
      t_reset();
      t_osc();
      t_freq();
      t_pwr();
      t_v3();
      t_rmw();
      test_done();
   end

   initial begin
      repeat (20000) @(posedge clk_i);
      n_errors++;
      test_done();
   end
endmodule : lcc_top_bench
`default_nettype wire
